// file: verilog/charge_control_sequencer.sv
// Purpose: charge mode sequencer, protections and fault flags
// Assumes: comparator inputs synchronous; host bits from i2c logic
// Notes: current outputs are codes for the analog loops
module charge_control_sequencer (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       supply_present,
    input  wire logic       input_ovp,
    input  wire logic       input_ovp_exit,
    input  wire logic       bat_below_precharge,
    input  wire logic       bat_near_regulation,
    input  wire logic       bat_below_recharge,
    input  wire logic       chg_below_termination,
    input  wire logic       temp_above_foldback,
    input  wire logic       temp_above_foldback_10,
    input  wire logic       temp_above_shutdown,
    input  wire logic       temp_below_shutdown_10,
    input  wire logic       host_cmd_valid,
    input  wire logic       host_write,
    input  wire logic [1:0] host_mode,
    input  wire logic       host_mode_wr,
    input  wire logic       host_term_en,
    input  wire logic       host_reduced_clr,
    input  wire logic       host_reset_bit,
    input  wire logic [1:0] host_ilim,
    input  wire logic [3:0] host_ichg,
    input  wire logic [5:0] host_vreg,
    input  wire logic [2:0] host_termination_current,
    input  wire logic       host_flag_access,
    input  wire logic       host_read_a,
    input  wire logic       host_read_b,
    output logic [1:0]      operation_mode_field,
    output logic            reduced_charge_limit_bit,
    output logic            termination_enable,
    output logic [1:0]      input_current_limit,
    output logic [3:0]      fast_charge_current,
    output logic [5:0]      regulation_voltage,
    output logic [2:0]      termination_current,
    output logic [3:0]      charge_current_cmd,
    output logic            taper_active,
    output logic            converter_on,
    output logic [1:0]      cur_select,
    output logic [5:0]      charge_state,
    output logic [0:0]      interrupt_flags_a,
    output logic [2:0]      interrupt_flags_b,
    output logic            int_n_o,
    output logic            int_n_oe
);
    chg_pkg::chg_state_t state_r;
    chg_pkg::chg_state_t state_nxt;
    logic [1:0] mode_r;
    logic       low_r;
    logic       term_r;
    logic       sup_d_r;
    logic       ovp_r;
    logic       hot_r;
    logic [3:0] ramp_r;
    logic       intp_r;
    logic [0:0] fa_r;
    logic [2:0] fb_r;
    logic       restart;
    logic       fault_hit;
    logic       blocked;
    tmr_if      tif ();

    function automatic logic charging(input logic [1:0] m);
        charging = m[1];
    endfunction : charging

    assign blocked   = ovp_r || hot_r;
    assign fault_hit = tif.boost_exp || tif.chg_exp;
    assign restart   = (supply_present && !sup_d_r)
        || (host_write && host_reset_bit)
        || (mode_r == chg_pkg::MODE_CHG_RC && term_r && bat_below_recharge
            && state_r == chg_pkg::ST_DONE)
        || (state_r == chg_pkg::ST_DONE && term_r && host_write
            && !host_term_en);
    assign tif.run     = (mode_r != chg_pkg::MODE_OFF);
    assign tif.restart = host_cmd_valid;
    assign tif.mode    = mode_r;

    safety_timer u_tmr (
        .ref_clk (ref_clk),
        .rst     (rst),
        .t       (tif)
    );

    // host bits; timeouts only touch the mode field
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_r <= chg_pkg::MODE_OFF;
        end else if (fault_hit) begin
            mode_r <= chg_pkg::MODE_OFF;
        end else if (host_write && host_mode_wr) begin
            mode_r <= host_mode;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            term_r <= 1'b0;
            input_current_limit <= chg_pkg::ILIM_100MA;
            fast_charge_current <= chg_pkg::ICHG_RESET;
            regulation_voltage  <= chg_pkg::VREG_RESET;
            termination_current <= chg_pkg::TERMINATION_CURRENT_RESET;
        end else if (host_write) begin
            term_r <= host_term_en;
            input_current_limit <= host_ilim;
            fast_charge_current <= host_ichg;
            regulation_voltage  <= host_vreg;
            termination_current <= host_termination_current;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sup_d_r <= 1'b0;
            low_r   <= 1'b0;
        end else begin
            sup_d_r <= supply_present;
            if (supply_present && !sup_d_r) begin
                low_r <= 1'b1;
            end else if (host_write && host_reduced_clr) begin
                low_r <= 1'b0;
            end
        end
    end

    // protection latches with hysteresis
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ovp_r <= 1'b0;
            hot_r <= 1'b0;
        end else begin
            if (input_ovp) begin
                ovp_r <= 1'b1;
            end else if (input_ovp_exit) begin
                ovp_r <= 1'b0;
            end
            if (temp_above_shutdown) begin
                hot_r <= 1'b1;
            end else if (temp_below_shutdown_10) begin
                hot_r <= 1'b0;
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            chg_pkg::ST_HIZ: begin
                if (mode_r == chg_pkg::MODE_BOOST && !blocked) begin
                    state_nxt = chg_pkg::ST_BOOST;
                end else if (charging(mode_r) && !blocked) begin
                    state_nxt = chg_pkg::ST_PRECHG;
                end
            end
            chg_pkg::ST_PRECHG: begin
                if (!bat_below_precharge) begin
                    state_nxt = chg_pkg::ST_FAST;
                end
            end
            chg_pkg::ST_FAST: begin
                if (bat_near_regulation) begin
                    state_nxt = chg_pkg::ST_VREG;
                end
            end
            chg_pkg::ST_VREG: begin
                if (term_r && chg_below_termination
                    && !bat_below_recharge) begin
                    state_nxt = chg_pkg::ST_DONE;
                end
            end
            chg_pkg::ST_DONE: state_nxt = chg_pkg::ST_DONE;
            chg_pkg::ST_BOOST: begin
                if (mode_r != chg_pkg::MODE_BOOST) begin
                    state_nxt = chg_pkg::ST_HIZ;
                end
            end
            default: state_nxt = chg_pkg::ST_HIZ;
        endcase
        if (state_r != chg_pkg::ST_BOOST && state_r != chg_pkg::ST_HIZ
            && restart) begin
            state_nxt = chg_pkg::ST_PRECHG;
        end
        if (mode_r == chg_pkg::MODE_OFF || blocked || fault_hit
            || (state_r != chg_pkg::ST_BOOST && state_r != chg_pkg::ST_HIZ
                && !charging(mode_r))) begin
            state_nxt = chg_pkg::ST_HIZ;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= chg_pkg::ST_HIZ;
        end else begin
            state_r <= state_nxt;
        end
    end

    // current ramp toward limited target with thermal foldback
    always_ff @(posedge ref_clk) begin
        if (rst || state_r != chg_pkg::ST_FAST && state_r != chg_pkg::ST_VREG
            || temp_above_foldback_10) begin
            ramp_r <= chg_pkg::RAMP_ZERO;
        end else if (temp_above_foldback) begin
            if (ramp_r != chg_pkg::RAMP_ZERO) begin
                ramp_r <= ramp_r - 4'h1;
            end
        end else if (ramp_r < fast_charge_current) begin
            ramp_r <= ramp_r + 4'h1;
        end else if (ramp_r > fast_charge_current) begin
            ramp_r <= fast_charge_current;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            charge_current_cmd <= chg_pkg::RAMP_ZERO;
            cur_select         <= chg_pkg::CUR_NONE;
            taper_active       <= 1'b0;
            converter_on       <= 1'b0;
        end else begin
            charge_current_cmd <= ramp_r;
            taper_active <= (state_r == chg_pkg::ST_VREG);
            converter_on <= (state_r != chg_pkg::ST_HIZ
                             && state_r != chg_pkg::ST_DONE);
            if (state_r == chg_pkg::ST_PRECHG) begin
                cur_select <= chg_pkg::CUR_PRE;
            end else if (state_r == chg_pkg::ST_FAST
                         || state_r == chg_pkg::ST_VREG) begin
                cur_select <= chg_pkg::CUR_FAST;
            end else begin
                cur_select <= chg_pkg::CUR_NONE;
            end
        end
    end

    // sticky flags: set wins over read clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fa_r <= 1'b0;
        end else if (input_ovp && !ovp_r) begin
            fa_r[chg_pkg::FLA_OVP] <= 1'b1;
        end else if (host_read_a) begin
            fa_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fb_r <= 3'h0;
        end else begin
            fb_r[chg_pkg::FLB_CHG_TO] <= tif.chg_exp
                || (fb_r[chg_pkg::FLB_CHG_TO] && !host_read_b);
            fb_r[chg_pkg::FLB_BOOST_TO] <= tif.boost_exp
                || (fb_r[chg_pkg::FLB_BOOST_TO] && !host_read_b);
            fb_r[chg_pkg::FLB_FAULT] <= (hot_r && charging(mode_r))
                || (fb_r[chg_pkg::FLB_FAULT] && !host_read_b);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            intp_r <= 1'b0;
        end else if ((input_ovp && !ovp_r) || fault_hit) begin
            intp_r <= 1'b1;
        end else if (host_flag_access) begin
            intp_r <= 1'b0;
        end
    end

    always_comb begin
        operation_mode_field     = mode_r;
        reduced_charge_limit_bit = low_r;
        termination_enable       = term_r;
        charge_state             = state_r;
        interrupt_flags_a        = fa_r;
        interrupt_flags_b        = fb_r;
        int_n_o                  = 1'b0;
        int_n_oe                 = !intp_r;
    end

    AST_OFF_HIZ: assert property (@(posedge ref_clk) disable iff (rst)
        mode_r == chg_pkg::MODE_OFF |=> state_r == chg_pkg::ST_HIZ)
        else $error("mode off but not high impedance");
    AST_TIMEOUT_MODE: assert property (@(posedge ref_clk) disable iff (rst)
        fault_hit |=> mode_r == chg_pkg::MODE_OFF && intp_r)
        else $error("timeout did not clear mode");
    AST_PARAMS_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
        fault_hit && !host_write |=> $stable(fast_charge_current)
        && $stable(regulation_voltage))
        else $error("timeout touched parameters");
    AST_LOW_SET: assert property (@(posedge ref_clk) disable iff (rst)
        supply_present && !sup_d_r |=> low_r)
        else $error("reduced charge not set");
    AST_PRE_FAST: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == chg_pkg::ST_PRECHG && !bat_below_precharge && !blocked
        && charging(mode_r) && !fault_hit && !restart
        |=> state_r == chg_pkg::ST_FAST)
        else $error("no fast charge entry");
    AST_NO_TERM: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == chg_pkg::ST_VREG && !term_r
        |=> state_r != chg_pkg::ST_DONE)
        else $error("terminated while disabled");
    AST_OVP_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
        input_ovp && !ovp_r |=> fa_r[chg_pkg::FLA_OVP] ##2 !converter_on)
        else $error("overvoltage not flagged");
    AST_INT_REL: assert property (@(posedge ref_clk) disable iff (rst)
        host_flag_access && !input_ovp && !fault_hit |=> !intp_r)
        else $error("interrupt not released");
    AST_HOT: assert property (@(posedge ref_clk) disable iff (rst)
        temp_above_shutdown |=> ##1 state_r == chg_pkg::ST_HIZ)
        else $error("no thermal shutdown");
    COV_DONE: cover property (@(posedge ref_clk) state_r == chg_pkg::ST_DONE);
    COV_BOOST: cover property (@(posedge ref_clk) tif.boost_exp);
    COV_OVP: cover property (@(posedge ref_clk) ovp_r ##1 !ovp_r);
endmodule : charge_control_sequencer

// file: verilog/chg_pkg.sv
// Purpose: constants and types for the charge control sequencer
// Assumes: 25 MHz ref_clk, synchronous active-high reset
// Notes: analog levels arrive as comparator bits from the power stage
// How it works
// - supply arrival sets reduced charge limit bit
// - below precharge threshold use small precharge current
// - fast charge ramps to programmed limited current
// - regulation voltage code accepted; taper near it
// - terminate at termination current above recharge level
// - termination disabled at reset; host enables
// - four events restart the charge cycle
// - thermal foldback reduces current to zero
// - shutdown temperature suspends charging until cooled
// - timer runs when mode nonzero; commands restart
// - boost timeout at 32 s clears mode
// - charge timeout at 32 minutes clears mode
// - timeout changes only the mode field
// - input overvoltage stops converter, sets flag
// - overvoltage exit resumes charging automatically
// - charging fault clears mode, sets flags; the thermal fault here sets only FLB_FAULT and keeps the mode
// - any flag access releases interrupt; read clears
// - mode zero keeps high impedance state
package chg_pkg;
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_BOOST  = 2'h1;
    localparam logic [1:0] MODE_CHG    = 2'h2;
    localparam logic [1:0] MODE_CHG_RC = 2'h3;
    localparam int  CLK_HZ           = 25000000;
    localparam int  BOOST_LIMIT_S    = 32;
    localparam int  CHARGE_LIMIT_MIN = 32;
    localparam int  CHARGE_LIMIT_S   = CHARGE_LIMIT_MIN * 60;
    localparam logic [10:0] BOOST_SECS  = 11'(BOOST_LIMIT_S);
    localparam logic [10:0] CHARGE_SECS = 11'(CHARGE_LIMIT_S);
    localparam logic [1:0] ILIM_100MA   = 2'h0;
    localparam logic [3:0] ICHG_RESET   = 4'h0;
    localparam logic [5:0] VREG_RESET   = 6'h00;
    localparam logic [2:0] TERMINATION_CURRENT_RESET  = 3'h0;
    localparam logic [3:0] RAMP_ZERO    = 4'h0;
    // flag bit positions inside interrupt_flags_b (FLB_*) and interrupt_flags_a (FLA_OVP)
    localparam int  FLB_CHG_TO   = 0;
    localparam int  FLB_BOOST_TO = 1;
    localparam int  FLB_FAULT    = 2;
    localparam int  FLA_OVP      = 0;
    typedef enum logic [5:0] {
        ST_HIZ     = 6'h01,
        ST_PRECHG  = 6'h02,
        ST_FAST    = 6'h04,
        ST_VREG    = 6'h08,
        ST_DONE    = 6'h10,
        ST_BOOST   = 6'h20
    } chg_state_t;
    typedef enum logic [1:0] {
        CUR_NONE  = 2'h0,
        CUR_PRE   = 2'h1,
        CUR_FAST  = 2'h2
    } cur_sel_t;
endpackage : chg_pkg

// file: verilog/tmr_if.sv
// Purpose: link between sequencer and safety timer
// Assumes: single clock domain
// Notes: none
interface tmr_if;
    logic       run;
    logic       restart;
    logic [1:0] mode;
    logic       boost_exp;
    logic       chg_exp;
    modport seq (output run, output restart, output mode,
                 input boost_exp, input chg_exp);
    modport tmr (input run, input restart, input mode,
                 output boost_exp, output chg_exp);
endinterface : tmr_if

// file: verilog/safety_timer.sv
// Purpose: safety timer from one seconds time base
// Assumes: expiry pulses last two cycles, until the cleared mode stops run
// Notes: counts whole seconds, compares by mode
module safety_timer (
    input  wire logic ref_clk,
    input  wire logic rst,
    tmr_if.tmr        t
);
    localparam logic [24:0] TICK_MAX = 25'(chg_pkg::CLK_HZ - 1);
    logic [24:0] tick_r;
    logic [10:0] secs_r;
    logic        bexp_r;
    logic        cexp_r;
    logic        sec_pulse;
    assign sec_pulse = (tick_r == TICK_MAX);
    assign t.boost_exp = bexp_r;
    assign t.chg_exp   = cexp_r;

    always_ff @(posedge ref_clk) begin
        if (rst || !t.run || t.restart) begin
            tick_r <= 25'h0;
            secs_r <= 11'h0;
        end else if (sec_pulse) begin
            tick_r <= 25'h0;
            if (secs_r != 11'h7FF) begin
                secs_r <= secs_r + 11'h1;
            end
        end else begin
            tick_r <= tick_r + 25'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bexp_r <= 1'b0;
            cexp_r <= 1'b0;
        end else begin
            bexp_r <= t.run && !t.restart
                      && t.mode == chg_pkg::MODE_BOOST
                      && secs_r == chg_pkg::BOOST_SECS;
            cexp_r <= t.run && !t.restart && t.mode[1]
                      && secs_r == chg_pkg::CHARGE_SECS;
        end
    end

    AST_NO_EXP_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
        !t.run |=> !bexp_r && !cexp_r)
        else $error("timer expired while idle");
    AST_RESTART_CLR: assert property (@(posedge ref_clk) disable iff (rst)
        t.restart |=> secs_r == 11'h0)
        else $error("restart did not clear timer");
endmodule : safety_timer

// file: testbench/host_model.sv
// Purpose: host processor model issuing command and flag accesses
// Assumes: every request is launched at a ref_clk rising edge
// Notes: each write is also a valid command, restarting the timer
module host_model (
    input  wire logic       ref_clk,
    output logic            host_cmd_valid,
    output logic            host_write,
    output logic [1:0]      host_mode,
    output logic            host_mode_wr,
    output logic            host_term_en,
    output logic            host_reduced_clr,
    output logic            host_reset_bit,
    output logic [1:0]      host_ilim,
    output logic [3:0]      host_ichg,
    output logic [5:0]      host_vreg,
    output logic [2:0]      host_termination_current,
    output logic            host_flag_access,
    output logic            host_read_a,
    output logic            host_read_b
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {host_cmd_valid, host_write, host_mode, host_mode_wr} = '0;
        {host_term_en, host_reduced_clr, host_reset_bit} = '0;
        {host_ilim, host_ichg, host_vreg, host_termination_current} = '0;
        {host_flag_access, host_read_a, host_read_b} = '0;
    end

    // parameters are held and taken with the next write
    task set_params(input logic [1:0] il, input logic [3:0] ic,
                    input logic [5:0] vr, input logic [2:0] it);
        @(posedge ref_clk);
        host_ilim <= il;
        host_ichg <= ic;
        host_vreg <= vr;
        host_termination_current <= it;
    endtask : set_params

    task write_cmd(input logic [1:0] m, input logic mw, input logic te,
                   input logic rc, input logic rb);
        @(posedge ref_clk);
        host_write <= 1'b1;
        host_cmd_valid <= 1'b1;
        host_mode <= m;
        host_mode_wr <= mw;
        host_term_en <= te;
        host_reduced_clr <= rc;
        host_reset_bit <= rb;
        @(posedge ref_clk);
        host_write <= 1'b0;
        host_cmd_valid <= 1'b0;
        host_mode_wr <= 1'b0;
        host_reduced_clr <= 1'b0;
        host_reset_bit <= 1'b0;
    endtask : write_cmd

    task flag_cmd(input logic ra, input logic rb);
        @(posedge ref_clk);
        host_flag_access <= 1'b1;
        host_read_a <= ra;
        host_read_b <= rb;
        @(posedge ref_clk);
        host_flag_access <= 1'b0;
        host_read_a <= 1'b0;
        host_read_b <= 1'b0;
    endtask : flag_cmd
endmodule : host_model

// file: testbench/charge_control_sequencer_bench.sv
// Purpose: self-checking bench for the charge control sequencer
// Assumes: comparator levels driven here, host bits by host_model
// Notes: safety timer limits are too long to reach in simulation
module charge_control_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int S_STATE = 0;
    localparam int S_CUR   = 1;
    localparam int S_CONV  = 2;
    localparam int S_INT   = 3;
    localparam int S_RED   = 4;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic supply_present = 1'b0;
    logic input_ovp = 1'b0;
    logic input_ovp_exit = 1'b1;
    logic bat_below_precharge = 1'b1;
    logic bat_near_regulation = 1'b0;
    logic bat_below_recharge = 1'b0;
    logic chg_below_termination = 1'b0;
    logic temp_above_foldback = 1'b0;
    logic temp_above_foldback_10 = 1'b0;
    logic temp_above_shutdown = 1'b0;
    logic temp_below_shutdown_10 = 1'b1;
    logic host_cmd_valid, host_write, host_mode_wr, host_term_en;
    logic host_reduced_clr, host_reset_bit, host_flag_access;
    logic host_read_a, host_read_b;
    logic [1:0] host_mode, host_ilim;
    logic [3:0] host_ichg;
    logic [5:0] host_vreg;
    logic [2:0] host_termination_current;
    logic [1:0] operation_mode_field, input_current_limit, cur_select;
    logic       reduced_charge_limit_bit, termination_enable, taper_active;
    logic       converter_on, int_n_o, int_n_oe;
    logic [3:0] fast_charge_current, charge_current_cmd;
    logic [5:0] regulation_voltage, charge_state;
    logic [2:0] termination_current, interrupt_flags_b;
    logic [0:0] interrupt_flags_a;
    int         fails = 0;
    int         compares = 0;
    int         k;

    always #20 ref_clk = ~ref_clk;

    host_model host_u (.ref_clk, .host_cmd_valid, .host_write, .host_mode,
        .host_mode_wr, .host_term_en, .host_reduced_clr, .host_reset_bit,
        .host_ilim, .host_ichg, .host_vreg, .host_termination_current,
        .host_flag_access, .host_read_a, .host_read_b);

    charge_control_sequencer dut_u (.ref_clk, .rst, .supply_present,
        .input_ovp, .input_ovp_exit, .bat_below_precharge,
        .bat_near_regulation, .bat_below_recharge, .chg_below_termination,
        .temp_above_foldback, .temp_above_foldback_10,
        .temp_above_shutdown, .temp_below_shutdown_10, .host_cmd_valid,
        .host_write, .host_mode, .host_mode_wr, .host_term_en,
        .host_reduced_clr, .host_reset_bit, .host_ilim, .host_ichg,
        .host_vreg, .host_termination_current, .host_flag_access, .host_read_a,
        .host_read_b, .operation_mode_field, .reduced_charge_limit_bit,
        .termination_enable, .input_current_limit, .fast_charge_current,
        .regulation_voltage, .termination_current, .charge_current_cmd,
        .taper_active, .converter_on, .cur_select, .charge_state,
        .interrupt_flags_a, .interrupt_flags_b, .int_n_o, .int_n_oe);

    task end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task check(input logic [7:0] got, input logic [7:0] exp,
               input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask : check

    function automatic logic [7:0] obs(input int sel);
        case (sel)
            S_STATE: obs = 8'(charge_state);
            S_CUR:   obs = 8'(charge_current_cmd);
            S_CONV:  obs = 8'(converter_on);
            S_INT:   obs = 8'(int_n_oe);
            default: obs = 8'(reduced_charge_limit_bit);
        endcase
    endfunction : obs

    // bounded wait for a value, or for leaving it when neg is set
    task wait_for(input int sel, input logic [7:0] exp, input logic neg,
                  input string what);
        int n;
        logic hit;
        hit = 1'b0;
        for (n = 0; n < 400 && !hit; n++) begin
            @(posedge ref_clk);
            #1;
            hit = neg ? (obs(sel) !== exp) : (obs(sel) === exp);
        end
        compares++;
        if (!hit) begin
            fails++;
            $display("unexpected at %0t: %s timed out", $time, what);
        end
    endtask : wait_for

    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    initial begin
        #(40 * 30000);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        step(1);
        check(8'(charge_state), 8'h01, "reset state");
        check(8'(operation_mode_field), 8'h00, "reset mode");
        check(8'(termination_enable), 8'h00, "reset term");
        check(8'(interrupt_flags_b), 8'h00, "reset flags");
        check(8'({int_n_oe, int_n_o}), 8'h02, "reset int");
        $display("test reset done");
        @(posedge ref_clk);
        supply_present <= 1'b1;
        wait_for(S_RED, 8'h01, 1'b0, "reduced set");
        host_u.set_params(2'h3, 4'hA, 6'h3F, 3'h5);
        host_u.write_cmd(chg_pkg::MODE_CHG, 1'b1, 1'b0, 1'b1, 1'b0);
        step(2);
        check(8'(reduced_charge_limit_bit), 8'h00, "reduced clr");
        check(8'(input_current_limit), 8'h03, "ilim");
        check(8'(fast_charge_current), 8'h0A, "ichg");
        check(8'(regulation_voltage), 8'h3F, "vreg");
        check(8'(termination_current), 8'h05, "termination_current");
        wait_for(S_STATE, 8'h02, 1'b0, "precharge");
        step(3);
        check(8'(cur_select), 8'h01, "pre current");
        @(posedge ref_clk);
        bat_below_precharge <= 1'b0;
        wait_for(S_STATE, 8'h04, 1'b0, "fast");
        step(3);
        check(8'(cur_select), 8'h02, "fast current");
        check(8'(converter_on), 8'h01, "converter");
        wait_for(S_CUR, 8'h0A, 1'b0, "ramp top");
        $display("test precharge done");
        @(posedge ref_clk);
        temp_above_foldback <= 1'b1;
        temp_above_foldback_10 <= 1'b1;
        wait_for(S_CUR, 8'h00, 1'b0, "foldback zero");
        @(posedge ref_clk);
        temp_above_foldback <= 1'b0;
        temp_above_foldback_10 <= 1'b0;
        wait_for(S_CUR, 8'h0A, 1'b0, "ramp back");
        $display("test foldback done");
        @(posedge ref_clk);
        bat_near_regulation <= 1'b1;
        chg_below_termination <= 1'b1;
        wait_for(S_STATE, 8'h08, 1'b0, "regulation");
        step(2);
        check(8'(taper_active), 8'h01, "taper");
        step(10);
        check(8'(charge_state), 8'h08, "no termination");
        host_u.write_cmd(chg_pkg::MODE_CHG_RC, 1'b1, 1'b1, 1'b0, 1'b0);
        wait_for(S_STATE, 8'h10, 1'b0, "done");
        for (k = 0; k < 3; k++) begin
            if (k == 0) begin
                @(posedge ref_clk);
                bat_below_recharge <= 1'b1;
            end else begin
                host_u.write_cmd(chg_pkg::MODE_CHG_RC, 1'b0, k == 1,
                                 1'b0, k == 1);
            end
            wait_for(S_STATE, 8'h10, 1'b1, "restart");
            check(8'(charge_state == 6'h01), 8'h00, "restart hiz");
            @(posedge ref_clk);
            bat_below_recharge <= 1'b0;
            if (k < 2) begin
                wait_for(S_STATE, 8'h10, 1'b0, "done again");
            end
        end
        $display("test termination done");
        @(posedge ref_clk);
        temp_above_shutdown <= 1'b1;
        temp_below_shutdown_10 <= 1'b0;
        wait_for(S_STATE, 8'h01, 1'b0, "shutdown");
        wait_for(S_CONV, 8'h00, 1'b0, "shutdown off");
        check(8'(interrupt_flags_b) & 8'h04, 8'h04, "thermal flag");
        @(posedge ref_clk);
        temp_above_shutdown <= 1'b0;
        temp_below_shutdown_10 <= 1'b1;
        wait_for(S_STATE, 8'h01, 1'b1, "resume");
        host_u.flag_cmd(1'b0, 1'b1);
        step(2);
        check(8'(interrupt_flags_b), 8'h00, "flags b clr");
        $display("test thermal done");
        @(posedge ref_clk);
        input_ovp <= 1'b1;
        input_ovp_exit <= 1'b0;
        wait_for(S_CONV, 8'h00, 1'b0, "ovp off");
        wait_for(S_INT, 8'h00, 1'b0, "ovp int");
        check(8'(interrupt_flags_a), 8'h01, "ovp flag");
        @(posedge ref_clk);
        input_ovp <= 1'b0;
        input_ovp_exit <= 1'b1;
        wait_for(S_CONV, 8'h01, 1'b0, "ovp resume");
        host_u.flag_cmd(1'b0, 1'b0);
        step(2);
        check(8'(int_n_oe), 8'h01, "int release");
        check(8'(interrupt_flags_a), 8'h01, "flag kept");
        host_u.flag_cmd(1'b1, 1'b0);
        step(2);
        check(8'(interrupt_flags_a), 8'h00, "flag a clr");
        $display("test overvoltage done");
        host_u.write_cmd(chg_pkg::MODE_BOOST, 1'b1, 1'b0, 1'b0, 1'b0);
        wait_for(S_STATE, 8'h20, 1'b0, "boost");
        host_u.write_cmd(chg_pkg::MODE_OFF, 1'b1, 1'b0, 1'b0, 1'b0);
        wait_for(S_STATE, 8'h01, 1'b0, "mode off");
        wait_for(S_CONV, 8'h00, 1'b0, "mode off conv");
        check(8'(operation_mode_field), 8'h00, "mode field");
        $display("test mode off done");
        end_of_test();
    end
endmodule : charge_control_sequencer_bench
